// ### design/status_event_filter.sv
// Overview of operation
// - Two groups, operation and questionable, alike except for instrument reset
// - Condition register mirrors live inputs, read harmless
// - Vanished condition clears its bit by itself
// - Event register latches accepted transitions until cleared
// - Reading event register returns it then clears
// - Instrument reset leaves event registers alone
// - Falling mask bit latches 1-to-0 transitions
// - Rising mask bit latches 0-to-1 transitions
// - Both mask bits set latch either edge
// - Both mask bits clear never latch
// - Enable masks events into group summary bit
// - Clear status clears events, keeps enables
// - Preset clears enable, falling; sets rising
// - Registers written and read as binary values
// - Enable and both masks read back
// - Instrument reset clears gone questionable conditions
// - Questionable masked events drive questionable summary
// - Clear status hits every group at once
//
// The register offsets and the AXI4-Lite slave port were chosen for this implementation.
`timescale 1ns/10ps
`include "status_event_cfg.svh"

module status_event_filter
  import status_event_pkg::*;
#(
  parameter int ADDR_W = 8,
  parameter int WIDTH  = 16
) (
  // Clock and reset
  input  wire logic              clock_i,
  input  wire logic              nrst_i,
  // Live status conditions
  input  wire logic [WIDTH-1:0]  operation_cond_i,
  input  wire logic [WIDTH-1:0]  questionable_cond_i,
  // AXI4-Lite write address and data
  input  wire logic [ADDR_W-1:0] awaddr_i,
  input  wire logic [2:0]        awprot_i,
  input  wire logic              awvalid_i,
  output logic                   awready_o,
  input  wire logic [31:0]       wdata_i,
  input  wire logic [3:0]        wstrb_i,
  input  wire logic              wvalid_i,
  output logic                   wready_o,
  // AXI4-Lite write response
  output logic [1:0]             bresp_o,
  output logic                   bvalid_o,
  input  wire logic              bready_i,
  // AXI4-Lite read
  input  wire logic [ADDR_W-1:0] araddr_i,
  input  wire logic [2:0]        arprot_i,
  input  wire logic              arvalid_i,
  output logic                   arready_o,
  output logic [31:0]            rdata_o,
  output logic [1:0]             rresp_o,
  output logic                   rvalid_o,
  input  wire logic              rready_i,
  // Summary bits toward the status byte
  output logic                   operation_summary_bit_o,
  output logic                   questionable_summary_bit_o
);

  localparam int GROUPS = 2;

  // The decoder looks at the low address byte, so fewer than 8 bits cannot work
  if (ADDR_W < 8 || ADDR_W > 32) begin : g_bad_addr_w
    $error("status_event_filter: ADDR_W must be 8..32");
  end
  if (WIDTH != 16) begin : g_bad_width
    $error("status_event_filter: register map holds 16-bit registers");
  end

  // ----------------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------------
  function automatic group_sel_t decode_sel(input logic [ADDR_W-1:0] addr, input int grp);
    logic [7:0] base;
    logic [7:0] a;
    base = (grp == 0) ? `SE_OPERATION_BASE : `SE_QUESTIONABLE_BASE;
    a = addr[7:0];
    decode_sel = SEL_NONE;
    if (addr[ADDR_W-1:7] == '0 && a >= base && a < 8'(base + `SE_GROUP_SPAN)) begin
      case (8'(a - base))
        `SE_EVENT_OFS:  decode_sel = SEL_EVENT;
        `SE_COND_OFS:   decode_sel = SEL_COND;
        `SE_ENABLE_OFS: decode_sel = SEL_ENABLE;
        `SE_FALL_OFS:   decode_sel = SEL_FALL;
        `SE_RISE_OFS:   decode_sel = SEL_RISE;
        default:        decode_sel = SEL_NONE;
      endcase
    end
  endfunction

  function automatic logic [WIDTH-1:0] merge_lanes(input logic [WIDTH-1:0] old,
                                                   input logic [31:0] data,
                                                   input logic [3:0] strb);
    logic [WIDTH-1:0] mask;
    mask = {{8{strb[1]}}, {8{strb[0]}}};
    merge_lanes = (old & ~mask) | (data[WIDTH-1:0] & mask);
  endfunction

  // ----------------------------------------------------------------------
  // Group instances
  // ----------------------------------------------------------------------
  logic [WIDTH-1:0] cond_in    [GROUPS];
  logic [WIDTH-1:0] grp_cond   [GROUPS];
  logic [WIDTH-1:0] grp_event  [GROUPS];
  logic [WIDTH-1:0] grp_enable [GROUPS];
  logic [WIDTH-1:0] grp_fall   [GROUPS];
  logic [WIDTH-1:0] grp_rise   [GROUPS];
  logic [WIDTH-1:0] grp_wdata  [GROUPS];
  logic             grp_sum    [GROUPS];
  logic             enable_wr  [GROUPS];
  logic             fall_wr    [GROUPS];
  logic             rise_wr    [GROUPS];
  logic             read_clear [GROUPS];
  logic             clear_pulse;
  logic             preset_pulse;
  logic             instrst_pulse;

  assign cond_in[0] = operation_cond_i;
  assign cond_in[1] = questionable_cond_i;

  genvar g;
  generate
    for (g = 0; g < GROUPS; g++) begin : grp
      status_group #(
        .WIDTH       (WIDTH),
        .DEFINED     (WIDTH'(`SE_DEFINED_BITS)),
        .INST_CLEARS (g == 1)
      ) u_group (
        .clock_i        (clock_i),
        .nrst_i         (nrst_i),
        .cond_pin_i     (cond_in[g]),
        .enable_wr_i    (enable_wr[g]),
        .fall_wr_i      (fall_wr[g]),
        .rise_wr_i      (rise_wr[g]),
        .wr_data_i      (grp_wdata[g]),
        .read_clear_i   (read_clear[g]),
        .clear_status_i (clear_pulse),
        .preset_i       (preset_pulse),
        .inst_reset_i   (instrst_pulse),
        .cond_o         (grp_cond[g]),
        .event_o        (grp_event[g]),
        .enable_o       (grp_enable[g]),
        .fall_o         (grp_fall[g]),
        .rise_o         (grp_rise[g]),
        .summary_o      (grp_sum[g])
      );
    end
  endgenerate

  // ----------------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------------
  // Address and data are taken together in one cycle, only once both are
  // offered; this costs a cycle but keeps the slave free of holding regs.
  logic        next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
  logic [1:0]  next_bresp, next_rresp;
  logic [31:0] next_rdata;
  logic        wr_fire, rd_fire, wr_hit, rd_hit;
  logic        ctrl_wr;
  group_sel_t  wsel [GROUPS];
  group_sel_t  rsel [GROUPS];

  always_comb begin
    next_awready = !awready_o && awvalid_i && wvalid_i && !bvalid_o;
    next_wready = next_awready;
    next_arready = !arready_o && arvalid_i && !rvalid_o;
    wr_fire = awready_o && awvalid_i;
    rd_fire = arready_o && arvalid_i;
    ctrl_wr = awaddr_i == ADDR_W'(`SE_CONTROL_ADDR);
    wr_hit = ctrl_wr;
    rd_hit = araddr_i == ADDR_W'(`SE_CONTROL_ADDR) || araddr_i == ADDR_W'(`SE_SUMMARY_ADDR);
    next_rdata = '0;
    if (araddr_i == ADDR_W'(`SE_SUMMARY_ADDR)) begin
      next_rdata[`SE_SUM_OPERATION_BIT] = operation_summary_bit_o;
      next_rdata[`SE_SUM_QUESTIONABLE_BIT] = questionable_summary_bit_o;
    end
    for (int i = 0; i < GROUPS; i++) begin
      wsel[i] = decode_sel(awaddr_i, i);
      rsel[i] = decode_sel(araddr_i, i);
      // Event and condition are read-only; a write there is refused
      if (wsel[i] == SEL_ENABLE || wsel[i] == SEL_FALL || wsel[i] == SEL_RISE) begin
        wr_hit = 1'b1;
      end
      if (rsel[i] != SEL_NONE) begin
        rd_hit = 1'b1;
      end
      enable_wr[i] = wr_fire && wsel[i] == SEL_ENABLE;
      fall_wr[i] = wr_fire && wsel[i] == SEL_FALL;
      rise_wr[i] = wr_fire && wsel[i] == SEL_RISE;
      case (wsel[i])
        SEL_ENABLE: grp_wdata[i] = merge_lanes(grp_enable[i], wdata_i, wstrb_i);
        SEL_FALL:   grp_wdata[i] = merge_lanes(grp_fall[i], wdata_i, wstrb_i);
        SEL_RISE:   grp_wdata[i] = merge_lanes(grp_rise[i], wdata_i, wstrb_i);
        default:    grp_wdata[i] = '0;
      endcase
      // Read data is captured in this same cycle, so the clear follows it
      read_clear[i] = rd_fire && rsel[i] == SEL_EVENT;
      case (rsel[i])
        SEL_EVENT:  next_rdata[WIDTH-1:0] = grp_event[i];
        SEL_COND:   next_rdata[WIDTH-1:0] = grp_cond[i];
        SEL_ENABLE: next_rdata[WIDTH-1:0] = grp_enable[i];
        SEL_FALL:   next_rdata[WIDTH-1:0] = grp_fall[i];
        SEL_RISE:   next_rdata[WIDTH-1:0] = grp_rise[i];
        default:    ;
      endcase
    end
    // Command strobes act only with lane 0 enabled
    clear_pulse = wr_fire && ctrl_wr && wstrb_i[0] && wdata_i[`SE_CTRL_CLEAR_BIT];
    preset_pulse = wr_fire && ctrl_wr && wstrb_i[0] && wdata_i[`SE_CTRL_PRESET_BIT];
    instrst_pulse = wr_fire && ctrl_wr && wstrb_i[0] && wdata_i[`SE_CTRL_INSTRST_BIT];

    next_bvalid = bvalid_o ? !bready_i : wr_fire;
    next_bresp = bresp_o;
    if (wr_fire) begin
      next_bresp = wr_hit ? RESP_OKAY : RESP_SLVERR;
    end
    next_rvalid = rvalid_o ? !rready_i : rd_fire;
    next_rresp = rresp_o;
    if (rd_fire) begin
      next_rresp = rd_hit ? RESP_OKAY : RESP_SLVERR;
    end
    if (!rd_fire) begin
      next_rdata = rdata_o;
    end else if (!rd_hit) begin
      next_rdata = '0;
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      awready_o <= 1'b0;
      wready_o <= 1'b0;
      bvalid_o <= 1'b0;
      bresp_o <= RESP_OKAY;
      arready_o <= 1'b0;
      rvalid_o <= 1'b0;
      rresp_o <= RESP_OKAY;
      rdata_o <= '0;
    end else begin
      awready_o <= next_awready;
      wready_o <= next_wready;
      bvalid_o <= next_bvalid;
      bresp_o <= next_bresp;
      arready_o <= next_arready;
      rvalid_o <= next_rvalid;
      rresp_o <= next_rresp;
      rdata_o <= next_rdata;
    end
  end

  // ----------------------------------------------------------------------
  // Summary outputs
  // ----------------------------------------------------------------------
  // Group summaries are already registered; one more stage keeps both the
  // pins and the summary register word on the same flop.
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      operation_summary_bit_o <= 1'b0;
      questionable_summary_bit_o <= 1'b0;
    end else begin
      operation_summary_bit_o <= grp_sum[0];
      questionable_summary_bit_o <= grp_sum[1];
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  write_resp_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
    (awready_o && awvalid_i) |=> bvalid_o)
    else $error("write response missing");

  read_resp_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
    (arready_o && arvalid_i) |=> rvalid_o)
    else $error("read response missing");

  read_clear_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
    (rd_fire && rsel[0] == SEL_EVENT) |=> rdata_o[WIDTH-1:0] == $past(grp_event[0])
      && (grp_event[0] & ~(grp_cond[0] ^ $past(grp_cond[0]))) == '0)
    else $error("event read returned wrong data");

  clear_keeps_enable_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
    (clear_pulse && !preset_pulse && !enable_wr[1]) |=> grp_enable[1] == $past(grp_enable[1]))
    else $error("clear status changed enable");

  questionable_summary_bit_summary_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
    ##2 questionable_summary_bit_o == |($past(grp_event[1], 2) & $past(grp_enable[1], 2)))
    else $error("questionable summary wrong");

  instrst_event_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
    (instrst_pulse && !clear_pulse && !read_clear[1])
      |=> (grp_event[1] & $past(grp_event[1])) == $past(grp_event[1]))
    else $error("instrument reset disturbed events");

endmodule

// ### design/status_event_cfg.svh
`ifndef STATUS_EVENT_CFG_SVH
`define STATUS_EVENT_CFG_SVH

// ----------------------------------------------------------------------
// Register byte offsets, group base plus register offset
// ----------------------------------------------------------------------
`define SE_OPERATION_BASE    8'h00
`define SE_QUESTIONABLE_BASE 8'h20
`define SE_GROUP_SPAN     8'h20
`define SE_EVENT_OFS      8'h00
`define SE_COND_OFS       8'h04
`define SE_ENABLE_OFS     8'h08
`define SE_FALL_OFS       8'h0c
`define SE_RISE_OFS       8'h10
`define SE_CONTROL_ADDR   8'h40
`define SE_SUMMARY_ADDR   8'h44

// ----------------------------------------------------------------------
// Control register strobe bits, summary register bits
// ----------------------------------------------------------------------
`define SE_CTRL_CLEAR_BIT 0
`define SE_CTRL_PRESET_BIT 1
`define SE_CTRL_INSTRST_BIT 2
`define SE_SUM_OPERATION_BIT    0
`define SE_SUM_QUESTIONABLE_BIT 1

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define SE_ENABLE_RST     16'h0000
`define SE_FALL_RST       16'h0000
`define SE_RISE_RST       16'hffff
`define SE_DEFINED_BITS   16'hffff

`endif

// ### design/status_event_pkg.sv
package status_event_pkg;

  typedef enum logic [1:0] {
    RESP_OKAY,
    RESP_EXOKAY,
    RESP_SLVERR,
    RESP_DECERR
  } axi_resp_t;

  typedef enum logic [2:0] {
    SEL_NONE,
    SEL_EVENT,
    SEL_COND,
    SEL_ENABLE,
    SEL_FALL,
    SEL_RISE
  } group_sel_t;

endpackage

// ### design/status_group.sv
`timescale 1ns/10ps
`include "status_event_cfg.svh"

module status_group
  import status_event_pkg::*;
#(
  parameter int                WIDTH        = 16,
  parameter logic [WIDTH-1:0]  DEFINED      = WIDTH'(`SE_DEFINED_BITS),
  parameter bit                INST_CLEARS  = 1'b0
) (
  // Clock and reset
  input  wire logic             clock_i,
  input  wire logic             nrst_i,
  // Live status conditions from outside
  input  wire logic [WIDTH-1:0] cond_pin_i,
  // Register access
  input  wire logic             enable_wr_i,
  input  wire logic             fall_wr_i,
  input  wire logic             rise_wr_i,
  input  wire logic [WIDTH-1:0] wr_data_i,
  input  wire logic             read_clear_i,
  // Command strobes
  input  wire logic             clear_status_i,
  input  wire logic             preset_i,
  input  wire logic             inst_reset_i,
  // Register contents
  output logic      [WIDTH-1:0] cond_o,
  output logic      [WIDTH-1:0] event_o,
  output logic      [WIDTH-1:0] enable_o,
  output logic      [WIDTH-1:0] fall_o,
  output logic      [WIDTH-1:0] rise_o,
  output logic                  summary_o
);

  if (WIDTH < 1 || WIDTH > 32) begin : g_bad_width
    $error("status_group: WIDTH must be 1..32");
  end

  // ----------------------------------------------------------------------
  // Condition synchroniser and event latch
  // ----------------------------------------------------------------------
  logic [WIDTH-1:0] sync1, sync2, sync3;
  logic [WIDTH-1:0] next_cond, next_event, next_enable, next_fall, next_rise;
  logic [WIDTH-1:0] set_bits;
  logic             clear_now;
  logic             next_summary;

  always_comb begin
    // A bit only moves once the last two stages agree, except when instrument reset clears it with INST_CLEARS set
    next_cond = (sync2 & sync3) | (cond_o & (sync2 ^ sync3));
    if (INST_CLEARS && inst_reset_i) begin
      next_cond = next_cond & sync2 & sync3;
    end
    set_bits = (rise_o & next_cond & ~cond_o)
             | (fall_o & ~next_cond & cond_o);
    clear_now = read_clear_i | clear_status_i;
    // Set wins over clear so no transition is lost; instrument reset is ignored
    next_event = (clear_now ? '0 : event_o) | set_bits;
    next_enable = enable_o;
    next_fall = fall_o;
    next_rise = rise_o;
    if (enable_wr_i) next_enable = wr_data_i;
    if (fall_wr_i) next_fall = wr_data_i;
    if (rise_wr_i) next_rise = wr_data_i;
    if (preset_i) begin
      next_enable = enable_o & ~DEFINED;
      next_fall = fall_o & ~DEFINED;
      next_rise = rise_o | DEFINED;
    end
    next_summary = |(event_o & enable_o);
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sync1 <= '0;
      sync2 <= '0;
      sync3 <= '0;
      cond_o <= '0;
      event_o <= '0;
      enable_o <= WIDTH'(`SE_ENABLE_RST);
      fall_o <= WIDTH'(`SE_FALL_RST);
      rise_o <= WIDTH'(`SE_RISE_RST);
      summary_o <= 1'b0;
    end else begin
      sync1 <= cond_pin_i;
      sync2 <= sync1;
      sync3 <= sync2;
      cond_o <= next_cond;
      event_o <= next_event;
      enable_o <= next_enable;
      fall_o <= next_fall;
      rise_o <= next_rise;
      summary_o <= next_summary;
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  rise_latch_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
    ((rise_o & next_cond & ~cond_o) != '0) |=> ((event_o & $past(rise_o & next_cond)) != '0))
    else $error("rising transition not latched");

  fall_latch_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
    ((fall_o & ~next_cond & cond_o) != '0) |=> ((event_o & $past(fall_o & cond_o)) != '0))
    else $error("falling transition not latched");

  event_hold_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
    !read_clear_i && !clear_status_i |=> ((event_o & $past(event_o)) == $past(event_o)))
    else $error("event bit dropped without clear");

  no_mask_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
    (rise_o == '0 && fall_o == '0 && (read_clear_i || clear_status_i)) |=> event_o == '0)
    else $error("event set with both filters off");

  preset_regs_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
    preset_i |=> ((enable_o & DEFINED) == '0 && (fall_o & DEFINED) == '0
                  && (rise_o & DEFINED) == DEFINED))
    else $error("preset values wrong");

  summary_or_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
    ##1 summary_o == |($past(event_o) & $past(enable_o)))
    else $error("summary does not follow masked events");

  cond_stable_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
    (sync2 == sync3 && !inst_reset_i) |=> cond_o == $past(sync3))
    else $error("condition does not mirror settled input");

endmodule

// ### bench/status_group_event_filter_bench.sv
`timescale 1ns/10ps
`include "status_event_cfg.svh"

module status_group_event_filter_bench
  import status_event_pkg::*;
;
  logic        clock_i;
  logic        nrst_i;
  logic [15:0] pin [2];
  logic [7:0]  awaddr, araddr, base [2];
  logic [31:0] wdata, rdata, seed;
  logic        awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, op_sum, qu_sum;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic [15:0] cexp [2], ev [2], en [2], fa [2], ri [2];
  int          n_errors, samples_checked, g, it;

  status_event_filter i_status_event_filter (
    .clock_i(clock_i), .nrst_i(nrst_i),
    .operation_cond_i(pin[0]), .questionable_cond_i(pin[1]),
    .awaddr_i(awaddr), .awprot_i(3'h0), .awvalid_i(awvalid), .awready_o(awready),
    .wdata_i(wdata), .wstrb_i(wstrb), .wvalid_i(wvalid), .wready_o(wready),
    .bresp_o(bresp), .bvalid_o(bvalid), .bready_i(bready),
    .araddr_i(araddr), .arprot_i(3'h0), .arvalid_i(arvalid), .arready_o(arready),
    .rdata_o(rdata), .rresp_o(rresp), .rvalid_o(rvalid), .rready_i(rready),
    .operation_summary_bit_o(op_sum), .questionable_summary_bit_o(qu_sum));

  initial begin
    clock_i = 1'b0;
    forever #10 clock_i = ~clock_i;
  end

  // ----------------------------------------------------------------------
  // Expectation helpers
  // ----------------------------------------------------------------------
  function automatic logic [15:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[15:0];
  endfunction

  // Bits latched by one settled condition change under the two filters
  function automatic logic [15:0] edges(input logic [15:0] o, n, f, r);
    return (~o & n & r) | (o & ~n & f);
  endfunction

  task automatic report_and_stop();
    if (n_errors == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, m, got, exp);
    end
  endtask

  task automatic hang(input string m);
    n_errors++;
    $display("CHECK FAILED at %0t: %s never answered", $time, m);
    report_and_stop();
  endtask

  // ----------------------------------------------------------------------
  // Register bus master
  // ----------------------------------------------------------------------
  // Each transfer first lets an edge pass, so no signal is assigned twice in a step
  task automatic axw(input logic [7:0] a, input logic [15:0] d, output logic [1:0] r);
    int n;
    @(posedge clock_i);
    awaddr  <= a;
    wdata   <= {16'h0000, d};
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    for (n = 0; n < 64; n++) begin
      @(posedge clock_i);
      if (awready && awvalid) awvalid <= 1'b0;
      if (wready && wvalid) wvalid <= 1'b0;
      if (bvalid && bready) begin
        r = bresp;
        bready <= 1'b0;
        return;
      end
    end
    hang("write");
  endtask

  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge clock_i);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    for (n = 0; n < 64; n++) begin
      @(posedge clock_i);
      if (arready && arvalid) arvalid <= 1'b0;
      if (rvalid && rready) begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        return;
      end
    end
    hang("read");
  endtask

  task automatic rdc(input logic [7:0] a, input logic [15:0] e, input logic [1:0] er,
                     input string m);
    logic [31:0] d;
    logic [1:0]  r;
    axr(a, d, r);
    chk(d, {16'h0000, e}, m);
    chk({30'h0, r}, {30'h0, er}, {m, " response"});
  endtask

  task automatic wrc(input logic [7:0] a, input logic [15:0] d, input logic [1:0] er,
                     input string m);
    logic [1:0] r;
    axw(a, d, r);
    chk({30'h0, r}, {30'h0, er}, m);
  endtask

  task automatic prog(input int k, input logic [15:0] e, f, r);
    en[k] = e;
    fa[k] = f;
    ri[k] = r;
    wrc(base[k] + `SE_ENABLE_OFS, e, RESP_OKAY, "enable write");
    wrc(base[k] + `SE_FALL_OFS, f, RESP_OKAY, "falling mask write");
    wrc(base[k] + `SE_RISE_OFS, r, RESP_OKAY, "rising mask write");
    rdc(base[k] + `SE_ENABLE_OFS, e, RESP_OKAY, "enable readback");
    rdc(base[k] + `SE_FALL_OFS, f, RESP_OKAY, "falling readback");
    rdc(base[k] + `SE_RISE_OFS, r, RESP_OKAY, "rising readback");
  endtask

  // Pins change once, then sit long enough for the synchroniser to settle
  task automatic set_pins(input logic [15:0] a, b);
    @(posedge clock_i);
    pin[0] <= a;
    pin[1] <= b;
    ev[0] = ev[0] | edges(cexp[0], a, fa[0], ri[0]);
    ev[1] = ev[1] | edges(cexp[1], b, fa[1], ri[1]);
    cexp[0] = a;
    cexp[1] = b;
    repeat (8) @(posedge clock_i);
  endtask

  task automatic check_sum();
    chk({31'h0, op_sum}, {31'h0, |(ev[0] & en[0])}, "operation summary");
    chk({31'h0, qu_sum}, {31'h0, |(ev[1] & en[1])}, "questionable summary");
    rdc(`SE_SUMMARY_ADDR, {14'h0, |(ev[1] & en[1]), |(ev[0] & en[0])}, RESP_OKAY, "summary");
  endtask

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    nrst_i = 1'b0;
    {awaddr, araddr, wdata, awvalid, wvalid, bready, arvalid, rready} = '0;
    wstrb = 4'hf;
    seed = 32'h53fbf9c6;
    n_errors = 0;
    samples_checked = 0;
    base[0] = `SE_OPERATION_BASE;
    base[1] = `SE_QUESTIONABLE_BASE;
    for (g = 0; g < 2; g++) begin
      {pin[g], cexp[g], ev[g], en[g], fa[g]} = '0;
      ri[g] = 16'hffff;
    end
    repeat (10) @(posedge clock_i);
    nrst_i <= 1'b1;
    for (g = 0; g < 2; g++) begin
      rdc(base[g] + `SE_EVENT_OFS, 16'h0000, RESP_OKAY, "event after reset");
      rdc(base[g] + `SE_COND_OFS, 16'h0000, RESP_OKAY, "condition after reset");
      rdc(base[g] + `SE_RISE_OFS, 16'hffff, RESP_OKAY, "rising after reset");
      wrc(base[g] + `SE_EVENT_OFS, 16'hffff, RESP_SLVERR, "event write refused");
    end
    rdc(8'h48, 16'h0000, RESP_SLVERR, "unmapped read");
    for (it = 0; it < 40; it++) begin
      for (g = 0; g < 2; g++) begin
        if (it == 0) prog(g, rnd(), 16'hffff, 16'hffff);
        else if (it == 1) prog(g, rnd(), 16'h0000, 16'h0000);
        else prog(g, rnd(), rnd(), rnd());
      end
      set_pins(rnd(), rnd());
      check_sum();
      for (g = 0; g < 2; g++) begin
        rdc(base[g] + `SE_COND_OFS, cexp[g], RESP_OKAY, "condition");
        if (it[0]) begin
          rdc(base[g] + `SE_EVENT_OFS, ev[g], RESP_OKAY, "event latch");
          ev[g] = 16'h0000;
          rdc(base[g] + `SE_EVENT_OFS, 16'h0000, RESP_OKAY, "event after read");
        end
      end
    end
    // Every bit flips with both filters open, so every event bit is latched
    prog(0, 16'hffff, 16'hffff, 16'hffff);
    prog(1, 16'hffff, 16'hffff, 16'hffff);
    set_pins(~cexp[0], ~cexp[1]);
    wrc(`SE_CONTROL_ADDR, 16'h0004, RESP_OKAY, "instrument reset");
    repeat (4) @(posedge clock_i);
    rdc(base[1] + `SE_COND_OFS, cexp[1], RESP_OKAY, "condition kept");
    check_sum();
    rdc(base[0] + `SE_EVENT_OFS, ev[0], RESP_OKAY, "event kept");
    ev[0] = 16'h0000;
    wrc(`SE_CONTROL_ADDR, 16'h0001, RESP_OKAY, "clear status");
    ev[1] = 16'h0000;
    repeat (4) @(posedge clock_i);
    check_sum();
    for (g = 0; g < 2; g++) begin
      rdc(base[g] + `SE_EVENT_OFS, 16'h0000, RESP_OKAY, "event cleared");
      rdc(base[g] + `SE_ENABLE_OFS, en[g], RESP_OKAY, "enable kept");
    end
    // Only the low byte lane is written; the high byte must keep its value
    wstrb <= 4'h1;
    wrc(base[0] + `SE_ENABLE_OFS, 16'h00a5, RESP_OKAY, "lane write");
    wstrb <= 4'hf;
    en[0] = {en[0][15:8], 8'ha5};
    rdc(base[0] + `SE_ENABLE_OFS, en[0], RESP_OKAY, "lane readback");
    wrc(`SE_CONTROL_ADDR, 16'h0002, RESP_OKAY, "preset");
    for (g = 0; g < 2; g++) begin
      rdc(base[g] + `SE_ENABLE_OFS, 16'h0000, RESP_OKAY, "preset enable");
      rdc(base[g] + `SE_FALL_OFS, 16'h0000, RESP_OKAY, "preset falling");
      rdc(base[g] + `SE_RISE_OFS, 16'hffff, RESP_OKAY, "preset rising");
    end
    rdc(`SE_CONTROL_ADDR, 16'h0000, RESP_OKAY, "control reads zero");
    report_and_stop();
  end
endmodule
